// File: servo_seq_regs.svh
`ifndef SERVO_SEQ_REGS_SVH
`define SERVO_SEQ_REGS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_ACTIVE 8'h04
`define OFS_RESTART 8'h08
`define OFS_TUNE 8'h0c
`define OFS_PRESET1 8'h10
`define OFS_PRESET2 8'h14
`define OFS_PRESET3 8'h18
`define OFS_ACCDEC 8'h1c
`define OFS_GAIN1 8'h20
`define OFS_GAIN2 8'h24
`define OFS_STATUS 8'h28
`define OFS_RESP 8'h2c
`define OFS_IRQ_STAT 8'h30
`define OFS_IRQ_MASK 8'h34
// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define RST_CTRL_MODE 16'h0000
`define MODE_POSITION 16'h0000
`define MODE_SPEED 16'h0002
`define RST_FILT_SEL 4'h2
`define RST_AUTOTUNE 4'h2
`define ATUNE_INTERP1 4'h3
`define ATUNE_INTERP2 4'h4
`define RST_RESP_LEVEL 5'h0c
`define RST_PRESET1 16'h03e8
`define RST_PRESET2 16'h05dc
`define RST_PRESET3 16'h07d0
`define RST_ACC_MS 16'h03e8
`define RST_DEC_MS 16'h01f4
`define RST_POS_GAIN 16'h002d
`define RST_INERTIA 16'h0046
`define RST_SPD_GAIN 16'h00b7
`define RST_SPD_INT 16'h0022
`define AUTO_INERTIA 16'h0046
`define VG_PER_LEVEL 16'h000f
// ---------------------------------------------------------------
// Timing and arithmetic constants
// ---------------------------------------------------------------
`define CLK_MHZ 250
`define FILT_MS_PER_STEP 2
`define DISP_DELAY_S 2
`define RATED_RPM 3000
`define TWO_PI_X1000 6283
`define VIC_NUMERATOR 4000
`endif

// File: servo_seq_pkg.sv
package servo_seq_pkg;
   typedef struct packed {
      logic rotate_cw_in;
      logic rotate_ccw_in;
      logic speed_select_hi;
      logic speed_select_lo;
      logic reverse_limit_in;
      logic forward_limit_in;
      logic emergency_halt_in;
      logic servo_enable_in;
   } din_t;
   typedef struct packed {
      logic [7:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef enum logic [1:0] {ST_FREE, ST_BRAKE, ST_LOCK, ST_RUN} run_state_t;
   typedef enum logic [1:0] {DIR_STOP, DIR_CCW, DIR_CW} dir_t;
endpackage

// File: input_debounce.sv
`timescale 1ns/100ps
module input_debounce #(
   parameter int W = 8,
   parameter int CW = 24,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,            // Core clock
   input wire logic i_rst,            // Synchronous reset
   input wire logic [W-1:0] i_din,    // Raw pin levels
   input wire logic [CW-1:0] i_limit, // Stable cycles required
   output logic [W-1:0] o_dout        // Filtered levels
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [CW-1:0] cnt_q [W];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= i_din;
         sync_q <= meta_q;
      end
   end

   // A change is accepted only after it stood for the whole limit
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dout <= RST_VAL;
         for (int b = 0; b < W; b++) begin
            cnt_q[b] <= '0;
         end
      end else begin
         for (int b = 0; b < W; b++) begin
            if (sync_q[b] == o_dout[b]) begin
               cnt_q[b] <= '0;
            end else if (cnt_q[b] >= i_limit) begin
               cnt_q[b] <= '0;
               o_dout[b] <= sync_q[b];
            end else begin
               cnt_q[b] <= cnt_q[b] + CW'(1);
            end
         end
      end
   end
endmodule

// File: servo_drive_run_sequencer.sv
`timescale 1ns/100ps
`include "servo_seq_regs.svh"
// Overview of operation
// - Select inputs pick zero speed or preset one, two or three.
// - One rotate input gives its direction; none or both stop with lock.
// - Servo enable off cuts drive and lets the motor coast.
// - Any alarm cuts drive and applies the dynamic brake.
// - Emergency halt off cuts drive, brakes and shows abnormal.
// - Limits permit their direction; a limit off stops and locks.
// - Servo on and stopped in position or speed mode with both limits off raises the limit alarm.
// - Servo enable on makes ready and holds servo lock.
// - Auto-tuning selection writes refused while servo enable is on.
// - Control mode and filter selection act only after a restart.
// - Servo off after power-up: display shows speed after two seconds.
// - Interpolation mode one: only position gain is user-set.
// - Interpolation mode two: position gain and inertia are user-set.
// - Filter selection two gives a four millisecond filter.
// - Response frequency is speed gain over (1 + inertia) times 2 pi.
// - Both rotate inputs equal: decelerate to stop, not cut.
module servo_drive_run_sequencer #(
   parameter int FILT_STEP_CYC = `FILT_MS_PER_STEP * `CLK_MHZ * 1000,
   parameter int DISP_CYC = `DISP_DELAY_S * `CLK_MHZ * 1000000,
   parameter int CYC_PER_MS = `CLK_MHZ * 1000,
   parameter int RATED_RPM = `RATED_RPM
) (
   input wire logic I_CORE_CLK,                      // 250 MHz core clock
   input wire logic I_RST,                           // Sync reset, high
   input wire servo_seq_pkg::din_t I_DIN,            // Contact inputs
   input wire logic I_PSEL,                          // APB select
   input wire logic I_PENABLE,                       // APB enable
   input wire servo_seq_pkg::apb_req_t I_APB,        // APB request
   output logic [31:0] O_PRDATA,                     // APB read data
   output logic O_PREADY,                            // APB ready
   output logic O_PSLVERR,                           // APB error
   output logic O_PWM_EN,                            // Drive stage on
   output logic O_DYN_BRAKE,                         // Dynamic brake on
   output logic O_SERVO_LOCK,                        // Shaft held at rest
   output logic signed [16:0] O_SPEED_CMD,           // Ramped speed, rpm
   output logic O_LIMIT_ALARM,                       // Limit alarm level
   output logic O_ABNORMAL_DISP,                     // Abnormal indication
   output logic O_DISP_SPEED,                        // Panel shows speed
   output logic O_IRQ                                // Interrupt level
);
   import servo_seq_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   din_t din_f;
   logic [15:0] mode_pend_q, mode_act_q;
   logic [3:0] filt_pend_q, filt_act_q, autotune_q;
   logic [4:0] resp_level_q;
   logic [15:0] preset1_q, preset2_q, preset3_q, acc_ms_q, dec_ms_q;
   logic [15:0] pos_gain_q, inertia_q, spd_gain_q, spd_int_q;
   logic [2:0] irq_stat_q, irq_mask_q, irq_ev;
   logic restart_q, pready_q, alarm_q;
   logic [23:0] filt_limit;
   logic [15:0] inertia_eff, spd_gain_eff, spd_int_eff, preset_sel;
   logic interp1, interp2, auto_vg, stopped, alarm_d, halt_d;
   logic access, wr_done, rd_done, mapped, tune_refused;
   logic [31:0] rd_mux, resp_freq;
   run_state_t state_q, state_d;
   dir_t dir_req;
   logic signed [16:0] speed_q, target;
   logic [31:0] step_cnt_q, step_per;
   logic [31:0] disp_cnt_q;
   logic disp_done_q;

   // ---------------------------------------------------------------
   // Arithmetic helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] ramp_period(input logic [15:0] ms);
      logic [47:0] p;
      p = 48'(ms) * 48'(CYC_PER_MS) / 48'(RATED_RPM);
      ramp_period = (p == 48'h0) ? 32'h1 : p[31:0];
   endfunction

   // Response frequency in 0.1 Hz; inertia is in tenths
   function automatic logic [31:0] freq_x10(input logic [15:0] vg,
                                            input logic [15:0] j);
      logic [47:0] den;
      den = (48'(j) + 48'd10) * 48'(`TWO_PI_X1000);
      freq_x10 = 32'((48'(vg) * 48'd100000) / den);
   endfunction

   // ---------------------------------------------------------------
   // Input filter
   // ---------------------------------------------------------------
   // Filter time is the selection times one step; value two is 4 ms
   assign filt_limit = 24'(32'(filt_act_q) * 32'(FILT_STEP_CYC));

   // Halt starts at its idle closed level so reset does not fake a halt edge
   input_debounce #(.W(8), .CW(24), .RST_VAL(8'h02)) u_filt (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_din(I_DIN),
      .i_limit(filt_limit),
      .o_dout(din_f)
   );

   // ---------------------------------------------------------------
   // Gain ownership
   // ---------------------------------------------------------------
   assign interp1 = (autotune_q == `ATUNE_INTERP1);
   assign interp2 = (autotune_q == `ATUNE_INTERP2);
   assign auto_vg = interp1 | interp2;
   assign inertia_eff = interp1 ? `AUTO_INERTIA : inertia_q;
   assign spd_gain_eff = auto_vg ?
      16'(32'(resp_level_q) * 32'(`VG_PER_LEVEL)) : spd_gain_q;
   assign spd_int_eff = !auto_vg ? spd_int_q : (spd_gain_eff == 16'h0) ?
      16'hffff : 16'((32'(`VIC_NUMERATOR) * (32'(inertia_eff) + 32'd10))
      / (32'd10 * 32'(spd_gain_eff)));
   assign resp_freq = freq_x10(spd_gain_eff, inertia_eff);

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // One wait state: data is captured in the first access cycle
   assign access = I_PSEL & I_PENABLE;
   assign wr_done = access & pready_q & I_APB.pwrite;
   assign rd_done = access & pready_q & ~I_APB.pwrite;
   assign tune_refused = wr_done & (I_APB.paddr == `OFS_TUNE)
                         & din_f.servo_enable_in;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0;
      case (I_APB.paddr)
         `OFS_MODE: rd_mux = {12'h0, filt_pend_q, mode_pend_q};
         `OFS_ACTIVE: rd_mux = {12'h0, filt_act_q, mode_act_q};
         `OFS_RESTART: rd_mux = 32'h0;
         `OFS_TUNE: rd_mux = {19'h0, resp_level_q, 4'h0, autotune_q};
         `OFS_PRESET1: rd_mux = {16'h0, preset1_q};
         `OFS_PRESET2: rd_mux = {16'h0, preset2_q};
         `OFS_PRESET3: rd_mux = {16'h0, preset3_q};
         `OFS_ACCDEC: rd_mux = {dec_ms_q, acc_ms_q};
         `OFS_GAIN1: rd_mux = {inertia_eff, pos_gain_q};
         `OFS_GAIN2: rd_mux = {spd_int_eff, spd_gain_eff};
         `OFS_STATUS: rd_mux = {speed_q[15:0], 3'h0, disp_done_q,
                                alarm_q, state_q, 1'b0, din_f};
         `OFS_RESP: rd_mux = resp_freq;
         `OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
         `OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pready_q <= 1'b0;
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h0;
         O_PSLVERR <= 1'b0;
      end else begin
         pready_q <= access & ~pready_q;
         O_PREADY <= access & ~pready_q;
         if (access & ~pready_q) begin
            O_PRDATA <= I_APB.pwrite ? 32'h0 : rd_mux;
            O_PSLVERR <= ~mapped;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         mode_pend_q <= `RST_CTRL_MODE;
         filt_pend_q <= `RST_FILT_SEL;
         mode_act_q <= `RST_CTRL_MODE;
         filt_act_q <= `RST_FILT_SEL;
         restart_q <= 1'b0;
      end else begin
         restart_q <= wr_done & (I_APB.paddr == `OFS_RESTART)
                      & I_APB.pwdata[0];
         if (wr_done & (I_APB.paddr == `OFS_MODE)) begin
            mode_pend_q <= I_APB.pwdata[15:0];
            filt_pend_q <= I_APB.pwdata[19:16];
         end
         if (restart_q) begin
            mode_act_q <= mode_pend_q;
            filt_act_q <= filt_pend_q;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         autotune_q <= `RST_AUTOTUNE;
         resp_level_q <= `RST_RESP_LEVEL;
      end else if (wr_done & (I_APB.paddr == `OFS_TUNE)) begin
         resp_level_q <= I_APB.pwdata[12:8];
         if (!din_f.servo_enable_in) begin
            autotune_q <= I_APB.pwdata[3:0];
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         preset1_q <= `RST_PRESET1;
         preset2_q <= `RST_PRESET2;
         preset3_q <= `RST_PRESET3;
         acc_ms_q <= `RST_ACC_MS;
         dec_ms_q <= `RST_DEC_MS;
      end else if (wr_done) begin
         case (I_APB.paddr)
            `OFS_PRESET1: preset1_q <= I_APB.pwdata[15:0];
            `OFS_PRESET2: preset2_q <= I_APB.pwdata[15:0];
            `OFS_PRESET3: preset3_q <= I_APB.pwdata[15:0];
            `OFS_ACCDEC: begin
               acc_ms_q <= I_APB.pwdata[15:0];
               dec_ms_q <= I_APB.pwdata[31:16];
            end
            default: ;
         endcase
      end
   end

   // Writes to gains owned by auto-tuning are dropped
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pos_gain_q <= `RST_POS_GAIN;
         inertia_q <= `RST_INERTIA;
         spd_gain_q <= `RST_SPD_GAIN;
         spd_int_q <= `RST_SPD_INT;
      end else if (wr_done && I_APB.paddr == `OFS_GAIN1) begin
         pos_gain_q <= I_APB.pwdata[15:0];
         if (!interp1) begin
            inertia_q <= I_APB.pwdata[31:16];
         end
      end else if (wr_done && I_APB.paddr == `OFS_GAIN2 && !auto_vg) begin
         spd_gain_q <= I_APB.pwdata[15:0];
         spd_int_q <= I_APB.pwdata[31:16];
      end
   end

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // Events: limit alarm rise, halt rise, refused write
   assign irq_ev = {tune_refused, halt_d & ~O_ABNORMAL_DISP, alarm_d & ~alarm_q};

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
         O_IRQ <= 1'b0;
      end else begin
         // A new event wins over the clearing read
         // Only bits that went out in the read data clear, so an event
         // caught during the wait state is not lost
         if (rd_done & (I_APB.paddr == `OFS_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~O_PRDATA[2:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
         if (wr_done & (I_APB.paddr == `OFS_IRQ_MASK)) begin
            irq_mask_q <= I_APB.pwdata[2:0];
         end
         O_IRQ <= |((irq_stat_q | irq_ev) & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   // A closed contact reads as one
   always_comb begin
      case ({din_f.speed_select_hi, din_f.speed_select_lo})
         2'b01: preset_sel = preset1_q;
         2'b10: preset_sel = preset2_q;
         2'b11: preset_sel = preset3_q;
         default: preset_sel = 16'h0;
      endcase
      case ({din_f.rotate_cw_in, din_f.rotate_ccw_in})
         2'b01: dir_req = DIR_CCW;
         2'b10: dir_req = DIR_CW;
         default: dir_req = DIR_STOP;
      endcase
      // Counter-clockwise is taken as forward
      if ((dir_req == DIR_CCW && !din_f.forward_limit_in) ||
          (dir_req == DIR_CW && !din_f.reverse_limit_in)) begin
         dir_req = DIR_STOP;
      end
      case (dir_req)
         DIR_CCW: target = 17'(signed'({1'b0, preset_sel}));
         DIR_CW: target = -17'(signed'({1'b0, preset_sel}));
         default: target = 17'sh0;
      endcase
   end

   // ---------------------------------------------------------------
   // Run state
   // ---------------------------------------------------------------
   assign stopped = (speed_q == 17'sh0);
   assign halt_d = ~din_f.emergency_halt_in;
   assign alarm_d = stopped & din_f.servo_enable_in
                    & ~din_f.forward_limit_in & ~din_f.reverse_limit_in
                    & ((mode_act_q == `MODE_POSITION) | (mode_act_q == `MODE_SPEED));

   always_comb begin
      if (halt_d || alarm_d) begin
         state_d = ST_BRAKE;
      end else if (!din_f.servo_enable_in) begin
         state_d = ST_FREE;
      end else if (target != 17'sh0 || !stopped) begin
         state_d = ST_RUN;
      end else begin
         state_d = ST_LOCK;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         state_q <= ST_FREE;
         alarm_q <= 1'b0;
         O_PWM_EN <= 1'b0;
         O_DYN_BRAKE <= 1'b0;
         O_SERVO_LOCK <= 1'b0;
         O_LIMIT_ALARM <= 1'b0;
         O_ABNORMAL_DISP <= 1'b0;
      end else begin
         state_q <= state_d;
         alarm_q <= alarm_d;
         O_LIMIT_ALARM <= alarm_d;
         O_ABNORMAL_DISP <= halt_d;
         O_PWM_EN <= (state_d == ST_RUN) | (state_d == ST_LOCK);
         O_DYN_BRAKE <= (state_d == ST_BRAKE);
         O_SERVO_LOCK <= (state_d == ST_LOCK);
      end
   end

   // ---------------------------------------------------------------
   // Speed ramp
   // ---------------------------------------------------------------
   // Moving away from zero uses accel time, toward zero decel time
   assign step_per = ramp_period((speed_q == 17'sh0 || ((target > speed_q) == (speed_q > 17'sh0)))
                                 && target != speed_q && target != 17'sh0
                                 ? acc_ms_q : dec_ms_q);

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         speed_q <= 17'sh0;
         step_cnt_q <= 32'h0;
      end else if (state_d == ST_FREE || state_d == ST_BRAKE) begin
         // Coasting or braking: the command falls away at once
         speed_q <= 17'sh0;
         step_cnt_q <= 32'h0;
      end else if (speed_q == target) begin
         step_cnt_q <= 32'h0;
      end else if (step_cnt_q + 32'h1 >= step_per) begin
         step_cnt_q <= 32'h0;
         speed_q <= (target > speed_q) ? speed_q + 17'sh1 : speed_q - 17'sh1;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         O_SPEED_CMD <= 17'sh0;
      end else begin
         O_SPEED_CMD <= speed_q;
      end
   end

   // ---------------------------------------------------------------
   // Panel display
   // ---------------------------------------------------------------
   // Counts only while servo enable stays off; an early enable restarts
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         disp_cnt_q <= 32'h0;
         disp_done_q <= 1'b0;
         O_DISP_SPEED <= 1'b0;
      end else begin
         if (!disp_done_q && din_f.servo_enable_in) begin
            disp_cnt_q <= 32'h0;
         end else if (!disp_done_q && disp_cnt_q + 32'h1 >= 32'(DISP_CYC)) begin
            disp_done_q <= 1'b1;
         end else if (!disp_done_q) begin
            disp_cnt_q <= disp_cnt_q + 32'h1;
         end
         O_DISP_SPEED <= disp_done_q;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_tune_write_on;
      wr_done && I_APB.paddr == `OFS_TUNE && din_f.servo_enable_in;
   endsequence
   sequence s_halt_seen;
      !din_f.emergency_halt_in;
   endsequence

   property p_preset_pick;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      dir_req == DIR_CCW && din_f.speed_select_lo && !din_f.speed_select_hi
      |-> target == 17'(signed'({1'b0, preset1_q}));
   endproperty
   a_preset_pick: assert property (p_preset_pick) else $error("preset pick");

   property p_both_rotate_stop;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      din_f.rotate_cw_in == din_f.rotate_ccw_in |-> target == 17'sh0;
   endproperty
   a_both_rotate_stop: assert property (p_both_rotate_stop) else $error("stop");

   property p_free_run;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      !din_f.servo_enable_in && !halt_d && !alarm_d
      |=> !O_PWM_EN && !O_DYN_BRAKE ##1 O_SPEED_CMD == 17'sh0;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run");

   property p_alarm_brake;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      alarm_d |=> O_DYN_BRAKE && !O_PWM_EN && O_LIMIT_ALARM;
   endproperty
   a_alarm_brake: assert property (p_alarm_brake) else $error("alarm brake");

   property p_halt;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      s_halt_seen |=> O_ABNORMAL_DISP && O_DYN_BRAKE && !O_PWM_EN;
   endproperty
   a_halt: assert property (p_halt) else $error("halt");

   property p_limit_alarm;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      stopped && din_f.servo_enable_in && !din_f.forward_limit_in
      && !din_f.reverse_limit_in
      && (mode_act_q == `MODE_SPEED || mode_act_q == `MODE_POSITION) |=> O_LIMIT_ALARM;
   endproperty
   a_limit_alarm: assert property (p_limit_alarm) else $error("limit alarm");

   property p_lock;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      din_f.servo_enable_in && !halt_d && !alarm_d && stopped && target == 17'sh0
      |=> O_SERVO_LOCK && O_PWM_EN;
   endproperty
   a_lock: assert property (p_lock) else $error("servo lock");

   property p_tune_refuse;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      s_tune_write_on |=> $stable(autotune_q) ##1 irq_stat_q[2];
   endproperty
   a_tune_refuse: assert property (p_tune_refuse) else $error("tune write");

   property p_decel;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      target == 17'sh0 && speed_q > 17'sh0 && state_d == ST_RUN
      |=> speed_q <= $past(speed_q);
   endproperty
   a_decel: assert property (p_decel) else $error("decel");
endmodule

// File: host_din_model.sv
`timescale 1ns/100ps
module host_din_model (
   input wire logic i_clk,                  // Core clock
   input wire servo_seq_pkg::din_t i_want,  // Contacts the host wants closed
   output servo_seq_pkg::din_t o_din        // Contact levels seen by the drive
);
   import servo_seq_pkg::*;
   // Closed to common reads one, open reads zero; moves only just after an edge
   always_ff @(posedge i_clk) begin
      o_din <= i_want;
   end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
`include "servo_seq_regs.svh"
module tb_top;
   import servo_seq_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic psel = 0;
   logic pen = 0;
   apb_req_t req = '0;
   din_t want = '0;
   din_t din;
   logic [31:0] prdata;
   logic [31:0] seed = 32'h7926;
   logic [31:0] v;
   logic pready, pslverr, pwm, brk, lock, alm, abn, disp, irq;
   logic signed [16:0] spd;
   logic [65:0] expq[$];
   logic [65:0] n;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   wire [6:0] fl = {pwm, brk, lock, alm, abn, disp, irq};
   host_din_model u_host (.i_clk(clk), .i_want(want), .o_din(din));
   servo_drive_run_sequencer #(.FILT_STEP_CYC(4), .DISP_CYC(50), .CYC_PER_MS(10)) u_dut (
      .I_CORE_CLK(clk), .I_RST(rst), .I_DIN(din), .I_PSEL(psel), .I_PENABLE(pen),
      .I_APB(req), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_PWM_EN(pwm), .O_DYN_BRAKE(brk), .O_SERVO_LOCK(lock), .O_SPEED_CMD(spd),
      .O_LIMIT_ALARM(alm), .O_ABNORMAL_DISP(abn), .O_DISP_SPEED(disp), .O_IRQ(irq));
   initial begin
      forever #2 clk = ~clk;
   end
   task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("Error %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop;
      end
   end
   // Read answers are matched in order against the notes left by the driver
   always @(posedge clk) begin
      if (psel && pen && pready === 1'b1 && !req.pwrite) begin
         n = expq.pop_front();
         chk("prdata", {pslverr, prdata} & n[65:33], n[32:0]);
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pen <= 0;
      req <= '{a, w, d};
      @(posedge clk) pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      pen <= 0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m = '1);
      expq.push_back({m, e});
      apb(0, a, 32'h0);
   endtask
   task flg(input string nm, input logic [6:0] e, input logic [6:0] m);
      chk(nm, {26'h0, fl & m}, {26'h0, e});
      $display("test %0s done", nm);
   endtask
   task st(input din_t w, input int k);
      want <= w;
      repeat (k) @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      rd(8'h3c, 33'h1_0000_0000);
      rd(`OFS_PRESET1, {17'h0, `RST_PRESET1});
      v = $random(seed) & 32'hffff;
      apb(1, `OFS_PRESET2, v);
      rd(`OFS_PRESET2, {1'b0, v});
      repeat (60) @(posedge clk);
      flg("halt_open_reset", 7'b0100110, 7'h7f);
      apb(1, `OFS_IRQ_MASK, 32'h1);
      apb(1, `OFS_MODE, 32'h0002_0002);
      rd(`OFS_ACTIVE, 33'h0002_0000);
      apb(1, `OFS_RESTART, 32'h1);
      rd(`OFS_ACTIVE, 33'h0002_0002);
      // Interpolation one: level 12 gives gain 180, integral 177, 3.5 Hz
      apb(1, `OFS_TUNE, 32'h0000_0c03);
      apb(1, `OFS_GAIN1, 32'h0064_0030);
      rd(`OFS_GAIN1, 33'h0046_0030);
      rd(`OFS_GAIN2, 33'h00b1_00b4);
      rd(`OFS_RESP, 33'h23);
      apb(1, `OFS_TUNE, 32'h0000_0c02);
      st(8'b0000_1111, 30);
      flg("servo_on", 7'b1010000, 7'b1111100);
      apb(1, `OFS_TUNE, 32'h0000_0c03);
      rd(`OFS_TUNE, 33'h0000_0c02, 33'h0000_1f0f);
      st(8'b0100_1111, 30);
      flg("no_preset", 7'b1010000, 7'b1110000);
      st(8'b0101_1111, 30);
      flg("run", 7'b1000000, 7'b1110000);
      chk("ccw_speed", {32'h0, spd > 0}, 33'h1);
      st(8'b1101_1111, 15);
      flg("decel", 7'b1000000, 7'b1110000);
      repeat (40) @(posedge clk);
      flg("both_on_stop", 7'b1010000, 7'b1110000);
      st(8'b0000_0011, 30);
      flg("limit_alarm", 7'b0101001, 7'b1111001);
      rd(`OFS_IRQ_STAT, 33'h5, 33'h5);
      repeat (3) @(posedge clk);
      flg("irq_clear", 7'b0000000, 7'b0000001);
      st(8'b0000_1110, 30);
      flg("servo_off", 7'b0000000, 7'b1111000);
      st(8'b0000_1101, 30);
      flg("halt_open", 7'b0100100, 7'b1100100);
      report_and_stop;
   end
endmodule
